// *** inc/hmv_pkg.sv ***
`default_nettype none
package hmv_pkg;
  // -------------------------------------------------------------
  // register map, word indexes (byte address = 4 x index)
  // -------------------------------------------------------------
  localparam int unsigned ADR_W          = 8;
  localparam logic [5:0]  IDX_FIRST_TAG  = 6'h09;
  localparam logic [5:0]  IDX_SECOND_TAG = 6'h0A;
  localparam logic [5:0]  IDX_WAKE_LOAD  = 6'h0B;
  localparam logic [5:0]  IDX_WAKE_CTRL  = 6'h0C;
  localparam logic [5:0]  IDX_RX_STATUS  = 6'h0D;

  // -------------------------------------------------------------
  // reset values and field positions
  // -------------------------------------------------------------
  localparam logic [15:0] TAG_RESET      = 16'hFFFF;
  localparam int unsigned WAKE_EN_BIT    = 2;
  localparam int unsigned WAKE_RCVD_BIT  = 6;
  localparam logic [31:0] WAKE_CTRL_MASK = 32'h0000_0004;
  localparam int unsigned STAT_TAG1_BIT  = 16;
  localparam int unsigned STAT_TAG2_BIT  = 17;
  localparam int unsigned STAT_LONG_BIT  = 18;

  // -------------------------------------------------------------
  // frame lengths and tag byte positions (zero based)
  // -------------------------------------------------------------
  localparam logic [15:0] LEN_PLAIN      = 16'h05EE;
  localparam logic [15:0] LEN_FIRST_TAG  = 16'h05F2;
  localparam logic [15:0] LEN_SECOND_TAG = 16'h0602;
  localparam logic [15:0] POS_TYPE_HI    = 16'h000C;
  localparam logic [15:0] POS_TYPE_LO    = 16'h000D;
  localparam logic [15:0] POS_MAX        = 16'hFFFF;

  // -------------------------------------------------------------
  // wake-up filter layout
  // -------------------------------------------------------------
  localparam int unsigned WAKE_WORDS     = 8;
  localparam int unsigned WF_MASK_WORD   = 0;
  localparam int unsigned WF_CMD_WORD    = 4;
  localparam int unsigned WF_OFS_WORD    = 5;
  localparam int unsigned WF_CRC_WORD    = 6;
  localparam logic [15:0] WF_SPAN        = 16'h0020;
  localparam logic [15:0] CRC_INIT       = 16'hFFFF;
  localparam logic [15:0] CRC_POLY       = 16'h8005;

  typedef enum logic [0:0] {RX_IDLE, RX_BODY} hmv_rx_e;
endpackage : hmv_pkg
`default_nettype wire

// *** rtl/hmv_pair_buf.sv ***
`timescale 1ns/1ns
`default_nettype none
// two-entry buffer; full rate with no combinational ready path
module hmv_pair_buf #(
  parameter int unsigned WIDTH = 9
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  logic [WIDTH-1:0] slot_reg [2];
  logic             wr_reg;
  logic             rd_reg;
  logic [1:0]       cnt_reg;
  logic             push;
  logic             pop;

  // handshake terms
  assign in_ready  = (cnt_reg != 2'h2);
  assign out_valid = (cnt_reg != 2'h0);
  assign out_data  = slot_reg[rd_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // storage, no reset needed on data
  always_ff @(posedge mclk) begin
    if (push) begin
      slot_reg[wr_reg] <= in_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge mclk) begin
    if (rst) begin
      wr_reg  <= 1'b0;
      rd_reg  <= 1'b0;
      cnt_reg <= 2'h0;
    end else begin
      if (push) wr_reg <= ~wr_reg;
      if (pop) rd_reg <= ~rd_reg;
      cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : hmv_pair_buf
`default_nettype wire

// *** rtl/hmv_top.sv ***
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// RL1 - first tag id matches bytes 13-14
// RL2 - second tag id matches bytes 13-14
// RL3 - first tag raises limit to 1522
// RL4 - second tag raises limit to 1538
// RL5 - equal ids: first tag wins, 1522
// RL6 - software keeps ids distinct, normally 8100h
// RL7 - tag ids bits 15:0, RW, reset FFFFh
// RL8 - filter write stores word, index advances
// RL9 - index wraps after eighth word
// RL10 - any reset rewinds filter index
// RL11 - filter location write-only, no reset
// RL12 - wake detection only while enable set
// RL13 - flag frames longer than current limit
module hmv_top #(
  parameter int unsigned LEN_W = 16
) (
  input  wire logic                      mclk,
  input  wire logic                      rst,
  input  wire logic                      soft_rst,
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [hmv_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [31:0]               wb_dat_i,
  output logic      [31:0]               wb_dat_o,
  output logic                           wb_ack_o,
  input  wire logic                      rx_valid,
  input  wire logic [7:0]                rx_data,
  input  wire logic                      rx_last,
  output logic                           rx_ready,
  output logic                           fwd_valid,
  output logic      [7:0]                fwd_data,
  output logic                           fwd_last,
  input  wire logic                      fwd_ready,
  output logic                           rx_stat_valid,
  output logic      [LEN_W-1:0]          rx_stat_len,
  output logic                           rx_stat_too_long,
  output logic                           rx_stat_tag1,
  output logic                           rx_stat_tag2,
  output logic                           wake_frame_seen
);
  import hmv_pkg::*;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // byte-lane merge for partial writes
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) r[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return r;
  endfunction : lane_merge

  // tag comparison, used for both identifiers
  function automatic logic tag_hit(input logic [15:0] id,
                                   input logic [15:0] ty,
                                   input logic        seen);
    return seen && (id == ty);
  endfunction : tag_hit

  // msb-first crc-16 over one byte
  function automatic logic [15:0] crc16_byte(input logic [15:0] c,
                                             input logic [7:0]  d);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      if (r[15] ^ d[i]) r = {r[14:0], 1'b0} ^ CRC_POLY;
      else r = {r[14:0], 1'b0};
    end
    return r;
  endfunction : crc16_byte

  // ---------------------------------------------------------------
  // register bus
  // ---------------------------------------------------------------
  logic [15:0] first_tag_identifier;
  logic [15:0] second_tag_identifier;
  logic [31:0] wake_filter_word [WAKE_WORDS];
  logic [2:0]  wake_idx_reg;
  logic [31:0] wake_ctrl_reg;
  logic [31:0] rx_status_reg;
  logic        ack_reg;
  logic [31:0] rdat_reg;
  logic        acc;
  logic        acc_wr;
  logic [5:0]  acc_idx;
  logic        wake_en;
  logic        wake_hit;
  logic [31:0] first_merge;
  logic [31:0] second_merge;
  logic [31:0] ctrl_merge;

  // one access per request; ack drops the cycle after
  assign acc      = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign acc_wr   = acc & wb_we_i;
  assign acc_idx  = wb_adr_i[ADR_W-1:2];
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;
  assign wake_en  = wake_ctrl_reg[WAKE_EN_BIT];

  // lane-merged write values for the register stores
  assign first_merge  = lane_merge({16'h0000, first_tag_identifier}, wb_dat_i, wb_sel_i);
  assign second_merge = lane_merge({16'h0000, second_tag_identifier}, wb_dat_i, wb_sel_i);
  assign ctrl_merge   = lane_merge(wake_ctrl_reg, wb_dat_i & WAKE_CTRL_MASK, wb_sel_i);

  always_ff @(posedge mclk) begin
    if (rst) ack_reg <= 1'b0;
    else ack_reg <= acc;
  end

  // read data; filter words never readable, unmapped reads zero
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdat_reg <= 32'h0000_0000;
    end else if (acc) begin
      case (acc_idx)
        IDX_FIRST_TAG:  rdat_reg <= {16'h0000, first_tag_identifier};
        IDX_SECOND_TAG: rdat_reg <= {16'h0000, second_tag_identifier};
        IDX_WAKE_CTRL:  rdat_reg <= wake_ctrl_reg;
        IDX_RX_STATUS:  rdat_reg <= rx_status_reg;
        default:        rdat_reg <= 32'h0000_0000;
      endcase
    end
  end

  // RL7 tag identifier storage
  always_ff @(posedge mclk) begin
    if (rst) begin
      first_tag_identifier  <= TAG_RESET;
      second_tag_identifier <= TAG_RESET;
    end else if (acc_wr) begin
      if (acc_idx == IDX_FIRST_TAG) first_tag_identifier <= first_merge[15:0];
      if (acc_idx == IDX_SECOND_TAG) second_tag_identifier <= second_merge[15:0];
    end
  end

  // RL8 RL11 indexed store, write-only, unreset
  always_ff @(posedge mclk) begin
    if (acc_wr && acc_idx == IDX_WAKE_LOAD) begin
      wake_filter_word[wake_idx_reg] <=
        lane_merge(wake_filter_word[wake_idx_reg], wb_dat_i, wb_sel_i);
    end
  end

  // RL10 rewind on reset or soft reset
  always_ff @(posedge mclk) begin
    if (rst || soft_rst) begin
      wake_idx_reg <= 3'h0;
    end else if (acc_wr && acc_idx == IDX_WAKE_LOAD) begin
      // RL9 natural wrap after word seven
      wake_idx_reg <= wake_idx_reg + 3'h1;
    end
  end

  // wake control: enable is RW, received flag is sticky, write one clears
  always_ff @(posedge mclk) begin
    if (rst) begin
      wake_ctrl_reg <= 32'h0000_0000;
    end else begin
      if (acc_wr && acc_idx == IDX_WAKE_CTRL) begin
        wake_ctrl_reg[WAKE_EN_BIT] <= ctrl_merge[WAKE_EN_BIT];
        if (wb_sel_i[0] && wb_dat_i[WAKE_RCVD_BIT])
          wake_ctrl_reg[WAKE_RCVD_BIT] <= 1'b0;
      end
      // a hit in the clearing cycle still lands
      if (wake_hit) wake_ctrl_reg[WAKE_RCVD_BIT] <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // receive path
  // ---------------------------------------------------------------
  hmv_rx_e     rx_state_reg;
  logic [15:0] pos_reg;
  logic [7:0]  type_hi_reg;
  logic [15:0] type_reg;
  logic [15:0] crc_reg;
  logic        take;
  logic        frame_end;
  logic [15:0] type_now;
  logic        type_seen;
  logic        hit1;
  logic        hit2;
  logic [15:0] limit;
  logic [15:0] len_now;
  logic [15:0] rel;
  logic [15:0] wf_ofs;
  logic        in_win;
  logic [15:0] crc_now;

  // the buffer decouples the receiver; a stall loses no byte
  hmv_pair_buf #(
    .WIDTH (9)
  ) u_buf (
    .mclk      (mclk),
    .rst       (rst),
    .in_valid  (rx_valid),
    .in_data   ({rx_last, rx_data}),
    .in_ready  (rx_ready),
    .out_valid (fwd_valid),
    .out_data  ({fwd_last, fwd_data}),
    .out_ready (fwd_ready)
  );

  assign take      = rx_valid & rx_ready;
  assign frame_end = take & rx_last;
  assign len_now   = (pos_reg == POS_MAX) ? POS_MAX : pos_reg + 16'h0001;

  // type field, including a frame whose last byte is byte 14
  assign type_now  = (pos_reg == POS_TYPE_LO) ? {type_hi_reg, rx_data} : type_reg;
  assign type_seen = (pos_reg >= POS_TYPE_LO);

  // RL1 first identifier compare
  assign hit1 = tag_hit(first_tag_identifier, type_now, type_seen);
  // RL2 RL5 second only when first misses
  assign hit2 = ~hit1 & tag_hit(second_tag_identifier, type_now, type_seen);

  // RL3 RL4 legal length in force
  always_comb begin
    limit = LEN_PLAIN;
    if (hit1) limit = LEN_FIRST_TAG;
    else if (hit2) limit = LEN_SECOND_TAG;
  end

  // frame state and byte position
  always_ff @(posedge mclk) begin
    if (rst) begin
      rx_state_reg <= RX_IDLE;
      pos_reg      <= 16'h0000;
    end else if (take) begin
      case (rx_state_reg)
        RX_IDLE: rx_state_reg <= rx_last ? RX_IDLE : RX_BODY;
        RX_BODY: rx_state_reg <= rx_last ? RX_IDLE : RX_BODY;
        default: rx_state_reg <= RX_IDLE;
      endcase
      pos_reg <= rx_last ? 16'h0000 : len_now;
    end
  end

  // capture the type/length bytes
  always_ff @(posedge mclk) begin
    if (rst) begin
      type_hi_reg <= 8'h00;
      type_reg    <= 16'h0000;
    end else if (take) begin
      if (pos_reg == POS_TYPE_HI) type_hi_reg <= rx_data;
      if (pos_reg == POS_TYPE_LO) type_reg <= {type_hi_reg, rx_data};
    end
  end

  // RL13 per-frame status pulse and held copy
  always_ff @(posedge mclk) begin
    if (rst) begin
      rx_stat_valid    <= 1'b0;
      rx_stat_len      <= '0;
      rx_stat_too_long <= 1'b0;
      rx_stat_tag1     <= 1'b0;
      rx_stat_tag2     <= 1'b0;
      rx_status_reg    <= 32'h0000_0000;
    end else begin
      rx_stat_valid <= frame_end;
      if (frame_end) begin
        rx_stat_len      <= LEN_W'(len_now);
        rx_stat_too_long <= (len_now > limit);
        rx_stat_tag1     <= hit1;
        rx_stat_tag2     <= hit2;
        rx_status_reg    <= {13'h0000, (len_now > limit), hit2, hit1, len_now};
      end
    end
  end

  // ---------------------------------------------------------------
  // wake-up frame check: filter 0, masked crc over a 32-byte window
  // ---------------------------------------------------------------
  assign wf_ofs  = {8'h00, wake_filter_word[WF_OFS_WORD][7:0]};
  assign rel     = pos_reg - wf_ofs;
  assign in_win  = (pos_reg >= wf_ofs) && (rel < WF_SPAN) &&
                   wake_filter_word[WF_MASK_WORD][rel[4:0]];
  assign crc_now = in_win ? crc16_byte(crc_reg, rx_data) : crc_reg;

  always_ff @(posedge mclk) begin
    if (rst) crc_reg <= CRC_INIT;
    else if (take) crc_reg <= rx_last ? CRC_INIT : crc_now;
  end

  // RL12 gated by the wake frame enable bit
  assign wake_hit = frame_end && wake_en && wake_filter_word[WF_CMD_WORD][0] &&
                    (crc_now == wake_filter_word[WF_CRC_WORD][15:0]);

  always_ff @(posedge mclk) begin
    if (rst) wake_frame_seen <= 1'b0;
    else wake_frame_seen <= wake_hit;
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_wr_first;
    acc_wr && acc_idx == IDX_FIRST_TAG && wb_sel_i == 4'hF;
  endsequence
  sequence s_wr_wake;
    acc_wr && acc_idx == IDX_WAKE_LOAD;
  endsequence

  property p_ack_pulse;
    acc |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack not one cycle");

  property p_first_wr;
    s_wr_first |=> first_tag_identifier == $past(wb_dat_i[15:0]);
  endproperty
  a_first_wr: assert property (p_first_wr) else $error("tag id write lost"); // RL7

  property p_tag_read;
    acc && !wb_we_i && acc_idx == IDX_SECOND_TAG |=> wb_dat_o[31:16] == 16'h0000;
  endproperty
  a_tag_read: assert property (p_tag_read) else $error("reserved bits set"); // RL7

  property p_wake_adv;
    s_wr_wake |=> wake_idx_reg == $past(wake_idx_reg) + 3'h1 || $past(soft_rst);
  endproperty
  a_wake_adv: assert property (p_wake_adv) else $error("index not advanced"); // RL8

  property p_wake_wrap;
    s_wr_wake and wake_idx_reg == 3'h7 |=> wake_idx_reg == 3'h0;
  endproperty
  a_wake_wrap: assert property (p_wake_wrap) else $error("index not wrapped"); // RL9

  property p_rewind;
    soft_rst |=> wake_idx_reg == 3'h0;
  endproperty
  a_rewind: assert property (p_rewind) else $error("index not rewound"); // RL10

  property p_wo_read;
    acc && !wb_we_i && acc_idx == IDX_WAKE_LOAD |=> wb_ack_o && wb_dat_o == 32'h0;
  endproperty
  a_wo_read: assert property (p_wo_read) else $error("filter readable"); // RL11

  property p_first_len;
    frame_end && hit1 |=> rx_stat_tag1 && rx_stat_too_long == ($past(len_now) > LEN_FIRST_TAG);
  endproperty
  a_first_len: assert property (p_first_len) else $error("first tag limit"); // RL1 RL3

  property p_second_len;
    frame_end && hit2 |=> rx_stat_tag2 && rx_stat_too_long == ($past(len_now) > LEN_SECOND_TAG);
  endproperty
  a_second_len: assert property (p_second_len) else $error("second tag limit"); // RL2 RL4

  property p_prec;
    frame_end && type_seen && first_tag_identifier == type_now |=> rx_stat_tag1 && !rx_stat_tag2;
  endproperty
  a_prec: assert property (p_prec) else $error("precedence broken"); // RL5

  property p_plain_len;
    frame_end && !hit1 && !hit2 |=> rx_stat_too_long == ($past(len_now) > LEN_PLAIN);
  endproperty
  a_plain_len: assert property (p_plain_len) else $error("plain limit"); // RL13

  property p_wake_gate;
    wake_frame_seen |-> $past(wake_en) && wake_ctrl_reg[WAKE_RCVD_BIT];
  endproperty
  a_wake_gate: assert property (p_wake_gate) else $error("wake while disabled"); // RL12
endmodule : hmv_top
`default_nettype wire

// *** verif/hmv_fabric_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// frame source on the receive side plus a stalling sink on the forward side
module hmv_fabric_model (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       rx_ready,
  output logic            rx_valid,
  output logic      [7:0] rx_data,
  output logic            rx_last,
  input  wire logic       fwd_valid,
  input  wire logic [7:0] fwd_data,
  input  wire logic       fwd_last,
  output logic            fwd_ready,
  input  wire logic       hold,
  input  wire logic       slow
);
  logic [2:0]  phase_reg;
  int unsigned got_cnt  = 0;
  int unsigned got_sum  = 0;
  int unsigned got_last = 0;

  // quiet lines at time zero
  initial begin
    rx_valid  = 1'b0;
    rx_data   = 8'h00;
    rx_last   = 1'b0;
    fwd_ready = 1'b0;
  end

  function automatic logic [7:0] byte_of(input int i, input logic [15:0] ty);
    if (i == 12) return ty[15:8];
    if (i == 13) return ty[7:0];
    return i[7:0] ^ 8'h5A;
  endfunction : byte_of

  // byte held until ready is seen at a falling edge, then taken at the next rising edge
  task automatic send_frame(input int len, input logic [15:0] ty);
    for (int i = 0; i < len; i++) begin
      rx_valid <= 1'b1;
      rx_data  <= byte_of(i, ty);
      rx_last  <= (i == len - 1);
      do @(negedge mclk); while (rx_ready !== 1'b1);
      @(posedge mclk);
    end
    rx_valid <= 1'b0;
    rx_data  <= ~rx_data;   // released line must not show a stale byte
    rx_last  <= 1'b0;
  endtask : send_frame

  // sink stalls three of eight cycles when slow, always when held
  always @(posedge mclk) begin
    phase_reg <= rst ? 3'h0 : phase_reg + 3'h1;
    fwd_ready <= !rst && !hold && !(slow && phase_reg < 3'h3);
    if (!rst && fwd_valid && fwd_ready) begin
      got_cnt  <= got_cnt + 1;
      got_sum  <= got_sum + fwd_data;
      got_last <= got_last + fwd_last;
    end
  end
endmodule : hmv_fabric_model
`default_nettype wire

// *** verif/host_mac_vlan_wakeup_filter_cfg_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module host_mac_vlan_wakeup_filter_cfg_tb;
  import hmv_pkg::*;
  logic        mclk     = 1'b0;
  logic        rst      = 1'b1;
  logic        soft_rst = 1'b0;
  logic        wb_cyc   = 1'b0;
  logic        wb_stb   = 1'b0;
  logic        wb_we    = 1'b0;
  logic [7:0]  wb_adr   = 8'h00;
  logic [3:0]  wb_sel   = 4'h0;
  logic [31:0] wb_wdat  = 32'h0;
  logic [31:0] wb_rdat, q;
  logic        wb_ack, rx_valid, rx_last, rx_ready, fwd_valid, fwd_last, fwd_ready;
  logic [7:0]  rx_data, fwd_data;
  logic        st_valid, st_long, st_tag1, st_tag2, wake_seen;
  logic [15:0] st_len;
  logic        hold = 1'b0;
  logic [3:0]  wsel = 4'hF;
  logic        slow = 1'b0;
  int          fails = 0;
  int          cmp_count = 0;
  int          wake_cnt = 0;

  always #2 mclk = ~mclk;

  hmv_top #(.LEN_W(16)) dut (
    .mclk(mclk), .rst(rst), .soft_rst(soft_rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_last(rx_last), .rx_ready(rx_ready), .fwd_valid(fwd_valid), .fwd_data(fwd_data),
    .fwd_last(fwd_last), .fwd_ready(fwd_ready), .rx_stat_valid(st_valid),
    .rx_stat_len(st_len), .rx_stat_too_long(st_long), .rx_stat_tag1(st_tag1),
    .rx_stat_tag2(st_tag2), .wake_frame_seen(wake_seen));

  hmv_fabric_model prt (
    .mclk(mclk), .rst(rst), .rx_ready(rx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_last(rx_last), .fwd_valid(fwd_valid), .fwd_data(fwd_data), .fwd_last(fwd_last),
    .fwd_ready(fwd_ready), .hold(hold), .slow(slow));

  // wake pulses are one cycle wide, so count them as they pass
  always @(posedge mclk) if (wake_seen === 1'b1) wake_cnt <= wake_cnt + 1;

  // ------------------------------------------------------------
  // shared helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
      fails++;
    end
  endtask : chk

  task automatic report_and_stop;
    if (fails == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  // classic cycle; entered just after a rising edge, leaves one idle cycle
  task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                         output logic [31:0] rd);
    int n;
    n = 0;
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= w;
    wb_adr  <= a;
    wb_sel  <= wsel;
    wb_wdat <= d;
    do begin @(negedge mclk); n++; end while (wb_ack !== 1'b1 && n < 64);
    chk(wb_ack, 1'b1);
    @(posedge mclk);
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
    @(posedge mclk);
  endtask : wb_xfer

  // send one frame, then judge status and what the sink received
  task automatic run_frame(input logic [15:0] ty, input int len, input logic [2:0] flags);
    int unsigned c0, s0, es, l0;
    int n;
    c0 = prt.got_cnt;
    l0 = prt.got_last;
    s0 = prt.got_sum;
    es = 0;
    n = 0;
    for (int i = 0; i < len; i++) es += prt.byte_of(i, ty);
    prt.send_frame(len, ty);
    while (st_valid !== 1'b1 && n < 4) begin @(negedge mclk); n++; end
    chk(st_valid, 1'b1);
    chk({st_tag1, st_tag2, st_long}, flags);
    chk(st_len, len);
    n = 0;
    while (prt.got_cnt != c0 + len && n < 64) begin @(posedge mclk); n++; end
    chk(prt.got_cnt, c0 + len);
    chk(prt.got_sum, s0 + es);
    chk(prt.got_last, l0 + 1);
    @(posedge mclk);
  endtask : run_frame

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_regs;
    wb_xfer(0, 8'h24, 0, q); chk(q, 32'h0000FFFF);
    wb_xfer(0, 8'h28, 0, q); chk(q, 32'h0000FFFF);
    wb_xfer(1, 8'h24, 32'hABCD8100, q);
    wb_xfer(0, 8'h24, 0, q); chk(q, 32'h00008100);
    wsel = 4'h1;
    wb_xfer(1, 8'h24, 32'h00001234, q);
    wsel = 4'hF;
    wb_xfer(0, 8'h24, 0, q); chk(q, 32'h00008134);
    wb_xfer(1, 8'h24, 32'h00008100, q);
    wb_xfer(1, 8'h28, 32'h000088A8, q);
    wb_xfer(0, 8'h28, 0, q); chk(q, 32'h000088A8);
    wb_xfer(1, 8'h2C, 32'h12345678, q);
    wb_xfer(0, 8'h2C, 0, q); chk(q, 32'h0);
    wb_xfer(1, 8'h3C, 32'hFFFFFFFF, q);
    wb_xfer(0, 8'h3C, 0, q); chk(q, 32'h0);
  endtask : t_regs

  // limits at both sides of each boundary, with the sink stalling
  task automatic t_tags;
    slow <= 1'b1;
    run_frame(16'h8100,   64, 3'b100);
    run_frame(16'h88A8,   64, 3'b010);
    run_frame(16'h0800, 1518, 3'b000);
    run_frame(16'h0800, 1519, 3'b001);
    run_frame(16'h8100, 1522, 3'b100);
    run_frame(16'h8100, 1523, 3'b101);
    run_frame(16'h88A8, 1538, 3'b010);
    run_frame(16'h88A8, 1539, 3'b011);
    run_frame(16'h88A8,   13, 3'b000);
    slow <= 1'b0;
  endtask : t_tags

  task automatic t_equal;
    wb_xfer(1, 8'h28, 32'h00008100, q);
    run_frame(16'h8100, 1523, 3'b101);
    wb_xfer(0, 8'h34, 0, q); chk(q, 32'h000505F3);
    run_frame(16'h8100, 1522, 3'b100);
    wb_xfer(0, 8'h34, 0, q); chk(q, 32'h000105F2);
  endtask : t_equal

  // receiver held off: buffer fills, refuses, then drains without loss
  task automatic t_fill;
    int unsigned c0;
    c0 = prt.got_cnt;
    hold <= 1'b1;
    @(posedge mclk);
    fork
      prt.send_frame(4, 16'h0800);
      begin
        repeat (6) @(negedge mclk);
        chk({rx_ready, fwd_valid}, 2'b01);
        @(posedge mclk);
        hold <= 1'b0;
      end
    join
    repeat (8) @(posedge mclk);
    chk(prt.got_cnt, c0 + 4);
  endtask : t_fill

  // empty mask: crc stays at its initial value, so word6 = FFFF matches
  task automatic load_filter(input logic [31:0] cmd);
    for (int i = 0; i < WAKE_WORDS; i++)
      wb_xfer(1, 8'h2C, (i == 4) ? cmd : ((i == 6) ? 32'h0000FFFF : 32'h0), q);
  endtask : load_filter

  task automatic wake_frame(input int exp_n);
    int w0;
    w0 = wake_cnt;
    run_frame(16'h0800, 40, 3'b000);
    repeat (2) @(posedge mclk);
    chk(wake_cnt - w0, exp_n);
  endtask : wake_frame

  task automatic soft_pulse;
    soft_rst <= 1'b1;
    @(posedge mclk);
    soft_rst <= 1'b0;
    @(posedge mclk);
  endtask : soft_pulse

  task automatic t_wake;
    soft_pulse();
    load_filter(32'h1);
    wb_xfer(1, 8'h30, 32'h4, q);
    wake_frame(1);
    wb_xfer(0, 8'h30, 0, q); chk(q, 32'h44);
    wb_xfer(1, 8'h30, 32'h40, q);
    wb_xfer(0, 8'h30, 0, q); chk(q, 32'h0);
    wake_frame(0);
    wb_xfer(1, 8'h30, 32'h4, q);
    load_filter(32'h0);
    wake_frame(0);
    for (int i = 0; i < 3; i++) wb_xfer(1, 8'h2C, 32'h0, q);
    soft_pulse();
    load_filter(32'h1);
    wake_frame(1);
  endtask : t_wake

  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    t_regs();
    t_tags();
    t_equal();
    t_fill();
    t_wake();
    report_and_stop();
  end

  // about four times the expected run length
  initial begin
    #320000;
    fails++;
    report_and_stop();
  end
endmodule : host_mac_vlan_wakeup_filter_cfg_tb
`default_nettype wire
